//--- verilog/pmcfg_pkg.sv
// Purpose: constants for the power-management configuration register slice
// Assumes: 8-bit registers on a plain strobe port, 10 MHz clock
// Notes: power-up defaults are loaded from otp inputs after reset release
`default_nettype none
package pmcfg_pkg;
    localparam logic [7:0] ADDR_OUT_CTRL2 = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h11;
    localparam logic [7:0] ADDR_PLL_CTRL = 8'h12;
    localparam logic [7:0] ADDR_PG_CTRL = 8'h13;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
    localparam logic [7:0] RST_OUT_CTRL2 = 8'h0a;
    localparam logic [7:0] RST_CONFIG = 8'h3c;
    localparam logic [7:0] RST_PLL_CTRL = 8'h02;
    localparam logic [7:0] RST_PG_CTRL = 8'h00;
    localparam logic [7:0] MASK_OUT_CTRL2 = 8'h3f;
    localparam logic [7:0] MASK_PLL_CTRL = 8'h5f;
    localparam logic [7:0] MASK_PG_CTRL = 8'h7f;
    localparam int CFG_START_RANGE = 7;
    localparam int CFG_STOP_RANGE = 6;
    localparam int CFG_CLK_PD = 5;
    localparam int CFG_IN3_PD = 4;
    localparam int CFG_IN2_PD = 3;
    localparam int CFG_IN1_PD = 2;
    localparam int CFG_WARN = 1;
    localparam int CFG_SPREAD = 0;
    localparam int PLL_ON = 6;
    localparam int PLL_FRAC = 5;
    localparam logic [4:0] RATE_MAX = 5'h17;
    localparam int OC2_PIN_SEL = 5;
    localparam int OC2_OD = 3;
    localparam int OC2_SRC_LO = 1;
    localparam int OC2_LEVEL = 0;
    localparam int PG_METHOD = 6;
    localparam int IRQ_CLK = 0;
    localparam int IRQ_PG = 1;
    localparam int CLK_HZ = 10_000_000;
    localparam int STEP_SHORT_US = 500;
    localparam int STEP_LONG_US = 1000;
    localparam int STEP_SHORT_CYC = (CLK_HZ / 1000) * STEP_SHORT_US / 1000;
    localparam int STEP_LONG_CYC = (CLK_HZ / 1000) * STEP_LONG_US / 1000;
    localparam int TEMP_WARN_LOW_C = 125;
    localparam int TEMP_WARN_HIGH_C = 140;
    localparam logic [7:0] WARN_LOW = 8'(TEMP_WARN_LOW_C);
    localparam logic [7:0] WARN_HIGH = 8'(TEMP_WARN_HIGH_C);
    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_RUN = 2'b01,
        DLY_DONE = 2'b10
    } pmcfg_dly_t;
endpackage
`default_nettype wire

//--- verilog/pmcfg_top.sv
// Purpose: configuration registers, output-three drive, pull-downs, pll and monitor controls
// Assumes: host keeps fractional bit 0 and changes rate code only with pll off
// Notes: otp defaults are captured on the first cycle after the synchronised reset release
`default_nettype none
module pmcfg_top
    import pmcfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // otp defaults
    input wire logic [7:0] otp_out_ctrl2,
    input wire logic [7:0] otp_config,
    input wire logic [7:0] otp_pll_ctrl,
    input wire logic [7:0] otp_pg_ctrl,
    // pins and events
    input wire logic enable_input_one,
    input wire logic enable_input_two,
    input wire logic enable_input_three,
    input wire logic ext_clock_present,
    input wire logic pg_fault_event,
    input wire logic startup_ctrl,
    // shared pin output three
    output logic general_output_three,
    output logic general_output_three_oe_n,
    // analog controls
    output logic ext_clock_pin_pulldown,
    output logic enable_three_pulldown,
    output logic enable_two_pulldown,
    output logic enable_one_pulldown,
    output logic [7:0] thermal_warning_threshold,
    output logic spread_modulation_on,
    output logic pll_run,
    output logic use_ext_clock,
    output logic [4:0] input_clock_rate_code,
    output logic rate_code_reserved,
    output logic supply_check_method,
    output logic [5:0] supply_check_enables,
    output logic startup_done,
    output logic irq
);
    import pmcfg_pkg::*;

    logic [1:0] rst_sync_ff;
    logic rst_int_n;
    logic loaded_ff;
    logic [7:0] out_ctrl2_ff, config_ff, pll_ctrl_ff, pg_ctrl_ff;
    logic [7:0] irq_stat_ff, irq_mask_ff;
    logic [2:0] en_s1_ff, en_s2_ff;
    logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
    logic pg_s1_ff, pg_s2_ff;
    logic st_s1_ff, st_s2_ff, st_s3_ff;
    logic [7:0] nxt_rdata;
    logic nxt_pin;
    logic clk_evt, pg_evt, pg_wr_change;
    logic [7:0] set_bits;
    pmcfg_dly_t dly_state_ff;
    logic [3:0] dly_steps_ff;
    logic [13:0] dly_cyc_ff;

    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_ff[1];

    // input synchronisers
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            en_s1_ff <= 3'b000;
            en_s2_ff <= 3'b000;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            pg_s1_ff <= 1'b0;
            pg_s2_ff <= 1'b0;
            st_s1_ff <= 1'b0;
            st_s2_ff <= 1'b0;
            st_s3_ff <= 1'b0;
        end else begin
            en_s1_ff <= {enable_input_three, enable_input_two, enable_input_one};
            en_s2_ff <= en_s1_ff;
            clk_s1_ff <= ext_clock_present;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            pg_s1_ff <= pg_fault_event;
            pg_s2_ff <= pg_s1_ff;
            st_s1_ff <= startup_ctrl;
            st_s2_ff <= st_s1_ff;
            st_s3_ff <= st_s2_ff;
        end
    end

    // configuration registers, otp load then host writes
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            loaded_ff <= 1'b0;
            out_ctrl2_ff <= RST_OUT_CTRL2;
            config_ff <= RST_CONFIG;
            pll_ctrl_ff <= RST_PLL_CTRL;
            pg_ctrl_ff <= RST_PG_CTRL;
        end else if (!loaded_ff) begin
            loaded_ff <= 1'b1;
            out_ctrl2_ff <= otp_out_ctrl2 & MASK_OUT_CTRL2;
            config_ff <= otp_config;
            pll_ctrl_ff <= otp_pll_ctrl & MASK_PLL_CTRL;
            pg_ctrl_ff <= otp_pg_ctrl & MASK_PG_CTRL;
        end else begin
            if (wr_hit(ADDR_OUT_CTRL2)) begin
                out_ctrl2_ff <= reg_wdata & MASK_OUT_CTRL2;
            end
            if (wr_hit(ADDR_CONFIG)) begin
                config_ff <= reg_wdata;
            end
            if (wr_hit(ADDR_PLL_CTRL)) begin
                // fractional bit held at 0 regardless of host
                pll_ctrl_ff <= reg_wdata & MASK_PLL_CTRL;
            end
            if (wr_hit(ADDR_PG_CTRL)) begin
                pg_ctrl_ff <= reg_wdata & MASK_PG_CTRL;
            end
        end
    end

    // interrupt events
    assign clk_evt = pll_ctrl_ff[PLL_ON] && (clk_s2_ff != clk_s3_ff);
    assign pg_wr_change = loaded_ff && wr_hit(ADDR_PG_CTRL)
        && ((reg_wdata & MASK_PG_CTRL) != pg_ctrl_ff);
    assign pg_evt = pg_wr_change || pg_s2_ff;
    always_comb begin
        set_bits = 8'h00;
        set_bits[IRQ_CLK] = clk_evt;
        set_bits[IRQ_PG] = pg_evt;
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_stat_ff <= 8'h00;
        end else if (reg_rd && reg_addr == ADDR_IRQ_STAT) begin
            irq_stat_ff <= set_bits;
        end else begin
            irq_stat_ff <= irq_stat_ff | set_bits;
        end
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_mask_ff <= 8'h00;
        end else if (wr_hit(ADDR_IRQ_MASK)) begin
            irq_mask_ff <= reg_wdata & 8'h03;
        end
    end

    // read data
    always_comb begin
        case (reg_addr)
            ADDR_OUT_CTRL2: nxt_rdata = out_ctrl2_ff;
            ADDR_CONFIG: nxt_rdata = config_ff;
            ADDR_PLL_CTRL: nxt_rdata = pll_ctrl_ff;
            ADDR_PG_CTRL: nxt_rdata = pg_ctrl_ff;
            ADDR_IRQ_STAT: nxt_rdata = irq_stat_ff;
            ADDR_IRQ_MASK: nxt_rdata = irq_mask_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // output three drive source
    always_comb begin
        case (out_ctrl2_ff[OC2_SRC_LO +: 2])
            2'b00: nxt_pin = out_ctrl2_ff[OC2_LEVEL];
            2'b01: nxt_pin = out_ctrl2_ff[OC2_LEVEL] & en_s2_ff[0];
            2'b10: nxt_pin = out_ctrl2_ff[OC2_LEVEL] & en_s2_ff[1];
            2'b11: nxt_pin = out_ctrl2_ff[OC2_LEVEL] & en_s2_ff[2];
            default: nxt_pin = 1'b0;
        endcase
    end

    // startup delay timer, step unit from range bit
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            dly_state_ff <= DLY_IDLE;
            dly_steps_ff <= 4'h0;
            dly_cyc_ff <= 14'h0000;
        end else begin
            case (dly_state_ff)
                DLY_IDLE: begin
                    if (st_s2_ff && !st_s3_ff) begin
                        dly_state_ff <= DLY_RUN;
                        dly_steps_ff <= 4'h0;
                        dly_cyc_ff <= 14'h0000;
                    end
                end
                DLY_RUN: begin
                    if (!st_s2_ff) begin
                        dly_state_ff <= DLY_IDLE;
                    end else if (dly_steps_ff == out_ctrl2_ff[7:4]) begin
                        dly_state_ff <= DLY_DONE;
                    end else if (dly_cyc_ff == (config_ff[CFG_START_RANGE]
                            ? 14'(STEP_LONG_CYC - 1) : 14'(STEP_SHORT_CYC - 1))) begin
                        dly_cyc_ff <= 14'h0000;
                        dly_steps_ff <= dly_steps_ff + 4'h1;
                    end else begin
                        dly_cyc_ff <= dly_cyc_ff + 14'h0001;
                    end
                end
                DLY_DONE: begin
                    if (!st_s2_ff) begin
                        dly_state_ff <= DLY_IDLE;
                    end
                end
                default: dly_state_ff <= DLY_IDLE;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            general_output_three <= 1'b0;
            general_output_three_oe_n <= 1'b1;
            ext_clock_pin_pulldown <= 1'b1;
            enable_three_pulldown <= 1'b1;
            enable_two_pulldown <= 1'b1;
            enable_one_pulldown <= 1'b1;
            thermal_warning_threshold <= WARN_LOW;
            spread_modulation_on <= 1'b0;
            pll_run <= 1'b0;
            use_ext_clock <= 1'b0;
            input_clock_rate_code <= 5'h02;
            rate_code_reserved <= 1'b0;
            supply_check_method <= 1'b0;
            supply_check_enables <= 6'h00;
            startup_done <= 1'b0;
            irq <= 1'b0;
        end else begin
            general_output_three <= nxt_pin;
            // pin driven only as output three; open-drain releases on high
            general_output_three_oe_n <= !(out_ctrl2_ff[OC2_PIN_SEL]
                && !(out_ctrl2_ff[OC2_OD] && nxt_pin));
            ext_clock_pin_pulldown <= config_ff[CFG_CLK_PD];
            enable_three_pulldown <= config_ff[CFG_IN3_PD];
            enable_two_pulldown <= config_ff[CFG_IN2_PD];
            enable_one_pulldown <= config_ff[CFG_IN1_PD];
            thermal_warning_threshold <= config_ff[CFG_WARN] ? WARN_HIGH : WARN_LOW;
            spread_modulation_on <= config_ff[CFG_SPREAD];
            pll_run <= pll_ctrl_ff[PLL_ON];
            use_ext_clock <= pll_ctrl_ff[PLL_ON] && clk_s2_ff
                && !out_ctrl2_ff[OC2_PIN_SEL];
            input_clock_rate_code <= pll_ctrl_ff[4:0];
            rate_code_reserved <= pll_ctrl_ff[4:0] > RATE_MAX;
            supply_check_method <= pg_ctrl_ff[PG_METHOD];
            supply_check_enables <= pg_ctrl_ff[5:0];
            startup_done <= dly_state_ff == DLY_DONE;
            irq <= |((irq_stat_ff | set_bits) & irq_mask_ff);
        end
    end

    // shutdown range bit is stored and passed with the config word
    // rate code changes rely on host keeping the pll off

    clk_irq_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (pll_ctrl_ff[PLL_ON] && clk_s2_ff != clk_s3_ff && !(reg_rd && reg_addr == ADDR_IRQ_STAT))
        |=> irq_stat_ff[IRQ_CLK]) else $error("clock event lost");
    pin_src_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (out_ctrl2_ff[2:1] == 2'b01 && !en_s2_ff[0]) |=> !general_output_three)
        else $error("source gating wrong");
    warn_lvl_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        config_ff[CFG_WARN] |=> thermal_warning_threshold == WARN_HIGH)
        else $error("warning level wrong");
    pull_dn_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        ##1 ext_clock_pin_pulldown == $past(config_ff[CFG_CLK_PD])
        && enable_one_pulldown == $past(config_ff[CFG_IN1_PD]))
        else $error("pull-down wrong");
    frac_zero_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        !pll_ctrl_ff[PLL_FRAC]) else $error("fractional bit set");
    pll_off_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        !pll_ctrl_ff[PLL_ON] |=> !use_ext_clock)
        else $error("ext clock with pll off");
    pg_chg_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        pg_wr_change |=> irq_stat_ff[IRQ_PG]) else $error("monitor change lost");
    rsvd_code_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (pll_ctrl_ff[4:0] > RATE_MAX) |=> rate_code_reserved)
        else $error("reserved code missed");
endmodule
`default_nettype wire

//--- test/pmcfg_host.sv
// Purpose: host model that programs the config slice over its register port
// Assumes: one-cycle strobes, read data stands only in the cycle after the strobe
// Notes: keeps the host-side duties for pll programming
`default_nettype none
module pmcfg_host
    import pmcfg_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pll_on = 1'b0;
    logic [4:0] rate = 5'h00;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_PLL_CTRL) begin
            v[PLL_FRAC] = 1'b0;
            if (pll_on) begin
                v[4:0] = rate;
            end
            pll_on = v[PLL_ON];
            rate = v[4:0];
        end
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- test/pmcfg_top_tb.sv
// Purpose: self-checking bench for the config slice
// Assumes: host model drives the register port, bench drives pins
// Notes: otp inputs are held at non-default values
`default_nettype none
module pmcfg_top_tb
    import pmcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] OTP_OC2 = 8'hcb;
    localparam logic [7:0] OTP_CFG = 8'h5a;
    localparam logic [7:0] OTP_PLL = 8'ha3;
    localparam logic [7:0] OTP_PG = 8'hc1;
    logic clk, rst_n, reg_wr, reg_rd, ext_clk, pg_ev, start_c, gpo, gpo_oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, thr;
    logic [2:0] en;
    logic ext_pd, pd3, pd2, pd1, spread, pll_run, use_ext, rate_res, pg_method, start_done, irq;
    logic [4:0] rate;
    logic [5:0] pg_en;
    logic [2:0] cc;
    logic [7:0] cfg_tab [4] = '{8'h02, 8'hfd, 8'h24, 8'h19};
    logic [2:0] en_tab [2] = '{3'b101, 3'b010};
    logic [7:0] scratch;
    logic exp_pin;
    int n_errors = 0;
    int check_count = 0;
    pmcfg_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pmcfg_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_out_ctrl2(OTP_OC2),
        .otp_config(OTP_CFG), .otp_pll_ctrl(OTP_PLL), .otp_pg_ctrl(OTP_PG),
        .enable_input_one(en[0]), .enable_input_two(en[1]), .enable_input_three(en[2]),
        .ext_clock_present(ext_clk), .pg_fault_event(pg_ev), .startup_ctrl(start_c),
        .general_output_three(gpo), .general_output_three_oe_n(gpo_oe_n),
        .ext_clock_pin_pulldown(ext_pd), .enable_three_pulldown(pd3),
        .enable_two_pulldown(pd2), .enable_one_pulldown(pd1),
        .thermal_warning_threshold(thr), .spread_modulation_on(spread), .pll_run(pll_run),
        .use_ext_clock(use_ext), .input_clock_rate_code(rate), .rate_code_reserved(rate_res),
        .supply_check_method(pg_method), .supply_check_enables(pg_en),
        .startup_done(start_done), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(d, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        #1;
        chk({7'h00, irq}, 8'h01);
    endtask
    initial begin
        #3_000_000;
        n_errors++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        en = 3'b000;
        ext_clk = 1'b0;
        pg_ev = 1'b0;
        start_c = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // defaults come from otp, reserved bits dropped
        rchk(ADDR_CONFIG, OTP_CFG);
        rchk(ADDR_PLL_CTRL, OTP_PLL & MASK_PLL_CTRL);
        rchk(ADDR_PG_CTRL, OTP_PG & MASK_PG_CTRL);
        rchk(ADDR_OUT_CTRL2, OTP_OC2 & MASK_OUT_CTRL2);
        rchk(ADDR_IRQ_MASK, 8'h00);
        // config field decode
        foreach (cfg_tab[i]) begin
            host_u.wr(ADDR_CONFIG, cfg_tab[i]);
            settle();
            chk({2'b00, ext_pd, pd3, pd2, pd1, 2'b00}, cfg_tab[i] & 8'h3c);
            chk({7'h00, spread}, {7'h00, cfg_tab[i][CFG_SPREAD]});
            chk(thr, cfg_tab[i][CFG_WARN] ? 8'h8c : 8'h7d);
            rchk(ADDR_CONFIG, cfg_tab[i]);
        end
        // output three source codes and levels
        foreach (en_tab[p]) begin
            en <= en_tab[p];
            for (int c = 0; c < 8; c++) begin
                cc = 3'(c);
                host_u.wr(ADDR_OUT_CTRL2, {5'b00100, cc});
                settle();
                chk({7'h00, gpo_oe_n}, 8'h00);
                exp_pin = (cc[2:1] == 2'b00) ? cc[0] : cc[0] & en_tab[p][cc[2:1] - 2'd1];
                chk({7'h00, gpo}, {7'h00, exp_pin});
            end
        end
        // pin back to clock input, pll off, reserved rate code
        host_u.wr(ADDR_OUT_CTRL2, 8'h01);
        host_u.wr(ADDR_IRQ_MASK, 8'h01);
        host_u.wr(ADDR_PLL_CTRL, 8'h18);
        ext_clk <= 1'b1;
        settle();
        chk({7'h00, gpo_oe_n}, 8'h01);
        chk({pll_run, use_ext, rate_res, rate}, 8'h38);
        chk({7'h00, irq}, 8'h00);
        // pll on, fractional bit request cleared by host
        host_u.wr(ADDR_PLL_CTRL, 8'h77);
        settle();
        chk({pll_run, use_ext, rate_res, rate}, 8'hd7);
        rchk(ADDR_PLL_CTRL, 8'h57);
        ext_clk <= 1'b0;
        wait_irq();
        chk({7'h00, use_ext}, 8'h00);
        rchk(ADDR_IRQ_STAT, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h00);
        // masked event stays sticky until unmasked
        host_u.wr(ADDR_IRQ_MASK, 8'h00);
        ext_clk <= 1'b1;
        settle();
        chk({7'h00, irq}, 8'h00);
        host_u.wr(ADDR_IRQ_MASK, 8'h01);
        wait_irq();
        rchk(ADDR_IRQ_STAT, 8'h01);
        host_u.wr(ADDR_PLL_CTRL, 8'h02);
        // supply monitor controls
        host_u.wr(ADDR_PG_CTRL, 8'hff);
        settle();
        chk({1'b0, pg_method, pg_en}, 8'h7f);
        rchk(ADDR_PG_CTRL, 8'h7f);
        host_u.wr(ADDR_PG_CTRL, 8'h15);
        settle();
        chk({1'b0, pg_method, pg_en}, 8'h15);
        host_u.rd(ADDR_IRQ_STAT, scratch);
        host_u.wr(ADDR_IRQ_MASK, 8'h02);
        pg_ev <= 1'b1;
        wait_irq();
        pg_ev <= 1'b0;
        rchk(ADDR_IRQ_STAT, 8'h02);
        // unmapped place
        host_u.wr(8'h30, 8'hff);
        rchk(8'h30, 8'h00);
        rchk(ADDR_CONFIG, 8'h19);
        // startup code 1, one step of each unit from the control rising edge
        host_u.wr(ADDR_OUT_CTRL2, 8'h10);
        for (int r = 0; r < 2; r++) begin
            host_u.wr(ADDR_CONFIG, (r == 1) ? 8'h80 : 8'h00);
            start_c <= 1'b1;
            repeat (((r == 1) ? STEP_LONG_CYC : STEP_SHORT_CYC) - 10) @(posedge clk);
            #1;
            chk({7'h00, start_done}, 8'h00);
            repeat (20) @(posedge clk);
            #1;
            chk({7'h00, start_done}, 8'h01);
            start_c <= 1'b0;
            settle();
            settle();
            chk({7'h00, start_done}, 8'h00);
        end
        results();
    end
endmodule
`default_nettype wire
